// ==== logic/obl_pkg.sv ====
// constants, types and helpers shared by the option byte loader files
package obl_pkg;

  // ==========================================================================
  // fetch geometry
  localparam int          OBL_BYTES     = 5;
  localparam logic [15:0] OBL_PRI_BASE  = 16'h0080;  // primary option block
  localparam logic [15:0] OBL_MIR_BASE  = 16'h1080;  // mirror block used under boot swap
  localparam logic [2:0]  OBL_LAST_IDX  = 3'h4;
  localparam logic [7:0]  OBL_BYTE_RST  = 8'h00;

  // byte slots inside the block
  localparam int OBL_SLOT_WDT  = 0;
  localparam int OBL_SLOT_LV   = 1;
  localparam int OBL_SLOT_RSV  = 2;
  localparam int OBL_SLOT_DBGM = 3;
  localparam int OBL_SLOT_DBGS = 4;

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam int          OBL_WB_AW      = 12;
  localparam logic [9:0]  OBL_IDX_WDT    = 10'h080;  // watchdog_oscillator_config
  localparam logic [9:0]  OBL_IDX_LV     = 10'h081;  // lowvolt_default_config
  localparam logic [9:0]  OBL_IDX_RSV    = 10'h082;  // reserved_config
  localparam logic [9:0]  OBL_IDX_DBGM   = 10'h083;  // debug_mode_config
  localparam logic [9:0]  OBL_IDX_DBGS   = 10'h084;  // debug_security_config
  localparam logic [9:0]  OBL_IDX_OSC    = 10'h085;  // internal_osc_mode_reg
  localparam logic [9:0]  OBL_IDX_STAT   = 10'h086;  // loader status

  // ==========================================================================
  // field positions
  localparam int OBL_WIN_HI      = 6;
  localparam int OBL_WIN_LO      = 5;
  localparam int OBL_AUTOSTART   = 4;
  localparam int OBL_PER_HI      = 2;
  localparam int OBL_PER_LO      = 0;
  localparam int OBL_OSC_LOCK    = 0;
  localparam int OBL_TOP_BIT     = 7;
  localparam int OBL_LV_ON       = 0;
  localparam int OBL_DBG_GATE    = 4;
  localparam int OBL_DBG_FORCE   = 0;
  localparam int OBL_DEN_HI      = 1;
  localparam int OBL_DEN_LO      = 0;
  localparam int OBL_OSC_STOP    = 1;
  localparam int OBL_ST_VALID    = 0;
  localparam int OBL_ST_SWAP     = 1;
  localparam int OBL_ST_ERR      = 2;
  localparam int OBL_ST_LVWR     = 3;

  localparam logic [4:0] OBL_EXP_MIN    = 5'h0A;   // overflow is 2^(10+code) slow cycles
  localparam logic [1:0] OBL_DEN_OFF    = 2'h0;
  localparam logic [1:0] OBL_DEN_BAD    = 2'h1;
  localparam logic [1:0] OBL_WIN_MIN    = 2'h0;
  localparam logic [2:0] OBL_PER_MIN    = 3'h0;
  localparam logic [6:0] OBL_PCT_25     = 7'h19;
  localparam logic [6:0] OBL_PCT_50     = 7'h32;
  localparam logic [6:0] OBL_PCT_75     = 7'h4B;
  localparam logic [6:0] OBL_PCT_100    = 7'h64;

  typedef enum logic [1:0] {
    OBL_ST_RESET = 2'b00,
    OBL_ST_FETCH = 2'b01,
    OBL_ST_DONE  = 2'b10
  } obl_state_t;

  // decoded static settings
  typedef struct packed {
    logic [1:0] wdt_window_code;
    logic [6:0] wdt_window_pct;
    logic       wdt_autostart;
    logic [4:0] wdt_period_exp;
    logic       slow_osc_lock;
    logic       lowvolt_default_on;
    logic       debug_stop_clock_gate;
    logic       debug_force;
    logic       debug_en;
    logic       debug_erase_on_fail;
    logic       cfg_error;
  } obl_cfg_t;

  // open window fraction in percent of the period
  function automatic logic [6:0] obl_window_pct(input logic [1:0] code);
    case (code)
      2'h0:    obl_window_pct = OBL_PCT_25;
      2'h1:    obl_window_pct = OBL_PCT_50;
      2'h2:    obl_window_pct = OBL_PCT_75;
      default: obl_window_pct = OBL_PCT_100;
    endcase
  endfunction

endpackage

// ==== logic/obl_decode.sv ====
// field decoder turning fetched option bytes into static settings
`timescale 1ns/1ns

module obl_decode
  import obl_pkg::*;
(
  input  wire logic [7:0] wdt_byte_i,       // first option byte
  input  wire logic [7:0] lv_byte_i,        // second option byte
  input  wire logic [7:0] dbg_mode_byte_i,  // fourth option byte
  input  wire logic [7:0] dbg_sec_byte_i,   // fifth option byte
  output obl_cfg_t        cfg_o             // decoded settings
);

  // ==========================================================================
  // decode
  // purely combinational, the top registers the result once per fetch
  always_comb begin
    cfg_o                       = '0;
    cfg_o.wdt_window_code       = wdt_byte_i[OBL_WIN_HI:OBL_WIN_LO];
    cfg_o.wdt_window_pct        = obl_window_pct(wdt_byte_i[OBL_WIN_HI:OBL_WIN_LO]);
    cfg_o.wdt_autostart         = wdt_byte_i[OBL_AUTOSTART];
    cfg_o.wdt_period_exp        = OBL_EXP_MIN + {2'h0, wdt_byte_i[OBL_PER_HI:OBL_PER_LO]};
    cfg_o.slow_osc_lock         = wdt_byte_i[OBL_OSC_LOCK];
    cfg_o.lowvolt_default_on    = lv_byte_i[OBL_LV_ON];
    cfg_o.debug_stop_clock_gate = dbg_mode_byte_i[OBL_DBG_GATE];
    cfg_o.debug_force           = dbg_mode_byte_i[OBL_DBG_FORCE];
    // the prohibited select 01 is treated as disabled and flagged
    cfg_o.debug_en              = dbg_sec_byte_i[OBL_DEN_HI];
    cfg_o.debug_erase_on_fail   = dbg_sec_byte_i[OBL_DEN_HI] & dbg_sec_byte_i[OBL_DEN_LO];
    // a badly programmed block still loads; software can see the flag
    cfg_o.cfg_error = (wdt_byte_i[OBL_PER_HI:OBL_PER_LO] == OBL_PER_MIN &&
                       wdt_byte_i[OBL_WIN_HI:OBL_WIN_LO] == OBL_WIN_MIN) |
                      wdt_byte_i[OBL_TOP_BIT] |
                      (dbg_sec_byte_i[OBL_DEN_HI:OBL_DEN_LO] == OBL_DEN_BAD);
  end

endmodule

// ==== logic/obl_top.sv ====
// option byte loader: reset-time fetch, decode, hold and register view
// Functional notes
// - fetch five option bytes at reset, apply
// - boot swap takes bytes from mirror block
// - window bits select 25/50/75/100 percent
// - autostart starts watchdog and illegal-access detect
// - period select gives 2^10..2^17 slow cycles
// - lock bit blocks software stopping slow oscillator
// - unlocked: no watchdog clock in HALT/STOP
// - watchdog keeps counting during self-programming
// - low-voltage bit picks 2.7 V hold
// - low-voltage bit only by programmer, unswapped
// - low-voltage change needs preceding chip erase
// - debug gate bit decides STOP clock keeping when debug-force is set
// - debug-force bit forces on-chip debug mode
// - debug-enable select decodes enable and erase
`timescale 1ns/1ns

module obl_top
  import obl_pkg::*;
(
  input  wire logic                 clk_i,               // 10 MHz system clock
  input  wire logic                 rst_i,               // synchronous reset, active high
  // flash read port
  output logic                      flash_req_o,         // read request, held until ack
  output logic [15:0]               flash_addr_o,        // byte address
  input  wire logic [7:0]           flash_rdata_i,       // read data, valid with ack
  input  wire logic                 flash_ack_i,         // read done pulse
  input  wire logic                 boot_swap_i,         // boot swap in effect
  // flash programming context
  input  wire logic                 prog_mode_i,         // dedicated programmer connected
  input  wire logic                 self_prog_i,         // self-programming in progress
  input  wire logic                 chip_erase_i,        // whole-chip erase done pulse
  input  wire logic                 block_erase_i,       // single block erase done pulse
  input  wire logic                 lv_write_i,          // programmer wrote second byte pulse
  // cpu state
  input  wire logic                 halt_i,              // cpu in HALT
  input  wire logic                 stop_i,              // cpu in STOP
  // settings
  output obl_cfg_t                  cfg_o,               // decoded settings
  output logic                      cfg_valid_o,         // fetch complete
  output logic                      wdt_run_o,           // watchdog counting enabled
  output logic                      illegal_acc_en_o,    // illegal-access detection enabled
  output logic                      wdt_clk_en_o,        // watchdog count clock supplied
  output logic                      slow_osc_stop_o,     // slow oscillator stopped
  output logic                      lvd_high_thr_o,      // hold reset to the higher level
  output logic                      debug_stop_osc_run_o,// keep osc and debug serial clock in STOP
  output logic                      lowvolt_wr_allow_o,  // second byte bit may be changed
  // classic wishbone slave
  input  wire logic                 wb_cyc_i,            // cycle
  input  wire logic                 wb_stb_i,            // strobe
  input  wire logic                 wb_we_i,             // write enable
  input  wire logic [OBL_WB_AW-1:0] wb_adr_i,            // byte address
  input  wire logic [3:0]           wb_sel_i,            // byte selects
  input  wire logic [31:0]          wb_dat_i,            // write data
  output logic [31:0]               wb_dat_o,            // read data
  output logic                      wb_ack_o             // acknowledge
);

  // ==========================================================================
  // state
  obl_state_t  state_r;
  logic [2:0]  idx_r;
  logic        swap_r;
  logic [7:0]  opt_mem_r [OBL_BYTES];
  obl_cfg_t    cfg_r;
  obl_cfg_t    cfg_nxt;
  logic        valid_r;
  logic        req_r;
  logic [15:0] addr_r;
  logic        wdt_run_r;
  logic        wdt_clk_en_r;
  logic        osc_stop_r;
  logic        lvd_r;
  logic        dbg_keep_r;
  logic        erase_armed_r;
  logic        lv_allow_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic        wb_req;
  logic [9:0]  wb_idx;
  logic [15:0] base;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_idx = wb_adr_i[OBL_WB_AW-1:2];
  assign base   = swap_r ? OBL_MIR_BASE : OBL_PRI_BASE;

  // ==========================================================================
  // fetch sequencer
  // boot swap is sampled once when the fetch starts so all five bytes come from one block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= OBL_ST_RESET;
      idx_r   <= 3'h0;
      swap_r  <= 1'b0;
      req_r   <= 1'b0;
      addr_r  <= 16'h0000;
    end else begin
      case (state_r)
        OBL_ST_RESET: begin
          swap_r  <= boot_swap_i;
          req_r   <= 1'b1;
          addr_r  <= boot_swap_i ? OBL_MIR_BASE : OBL_PRI_BASE;
          idx_r   <= 3'h0;
          state_r <= OBL_ST_FETCH;
        end
        OBL_ST_FETCH: begin
          if (flash_ack_i) begin
            if (idx_r == OBL_LAST_IDX) begin
              req_r   <= 1'b0;
              state_r <= OBL_ST_DONE;
            end else begin
              idx_r  <= idx_r + 3'h1;
              addr_r <= base + {13'h0000, idx_r + 3'h1};
            end
          end
        end
        OBL_ST_DONE: begin
          req_r <= 1'b0;
        end
        default: begin
          state_r <= OBL_ST_RESET;
          req_r   <= 1'b0;
        end
      endcase
    end
  end

  // byte storage, written only while fetching
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < OBL_BYTES; i++) begin
        opt_mem_r[i] <= OBL_BYTE_RST;
      end
    end else if (state_r == OBL_ST_FETCH && flash_ack_i) begin
      opt_mem_r[idx_r] <= flash_rdata_i;
    end
  end

  // ==========================================================================
  // decode and hold
  obl_decode u_decode (
    .wdt_byte_i      (opt_mem_r[OBL_SLOT_WDT]),
    .lv_byte_i       (opt_mem_r[OBL_SLOT_LV]),
    .dbg_mode_byte_i (opt_mem_r[OBL_SLOT_DBGM]),
    .dbg_sec_byte_i  (opt_mem_r[OBL_SLOT_DBGS]),
    .cfg_o           (cfg_nxt)
  );

  // settings are captured once; later flash changes cannot reach them until reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r   <= '0;
      valid_r <= 1'b0;
    end else if (state_r == OBL_ST_DONE && !valid_r) begin
      cfg_r   <= cfg_nxt;
      valid_r <= 1'b1;
    end
  end

  // ==========================================================================
  // watchdog and oscillator controls
  // self_prog_i deliberately does not enter the gate: the count keeps going
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_run_r    <= 1'b0;
      wdt_clk_en_r <= 1'b0;
    end else begin
      wdt_run_r    <= valid_r & cfg_r.wdt_autostart;
      wdt_clk_en_r <= valid_r & cfg_r.wdt_autostart &
                      ~(~cfg_r.slow_osc_lock & (halt_i | stop_i));
    end
  end

  // software stop bit; with the lock set a 1 is refused, a 0 is always taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_stop_r <= 1'b0;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_idx == OBL_IDX_OSC) begin
      if (!wb_dat_i[OBL_OSC_STOP]) begin
        osc_stop_r <= 1'b0;
      end else if (valid_r && !cfg_r.slow_osc_lock) begin
        osc_stop_r <= 1'b1;
      end
    end
  end

  // low-voltage level and debug STOP clock keeping
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvd_r      <= 1'b0;
      dbg_keep_r <= 1'b0;
    end else begin
      lvd_r      <= valid_r & cfg_r.lowvolt_default_on;
      dbg_keep_r <= valid_r & cfg_r.debug_force & stop_i &
                    ~cfg_r.debug_stop_clock_gate;
    end
  end

  // ==========================================================================
  // low-voltage bit write permission
  // arming survives until the bit is written or a block erase spoils it; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erase_armed_r <= 1'b0;
    end else if (chip_erase_i) begin
      erase_armed_r <= 1'b1;
    end else if (block_erase_i || lv_write_i) begin
      erase_armed_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lv_allow_r <= 1'b0;
    end else begin
      // a block erase or write in this cycle withdraws permission at once, not one cycle late
      lv_allow_r <= prog_mode_i & ~self_prog_i & ~boot_swap_i & erase_armed_r &
                    ~block_erase_i & ~lv_write_i;
    end
  end

  // ==========================================================================
  // wishbone slave
  // one wait state: ack in the cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
    end
  end

  // unmapped addresses read zero and are acknowledged like any other
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_idx)
        OBL_IDX_WDT:  dat_r <= {24'h000000, opt_mem_r[OBL_SLOT_WDT]};
        OBL_IDX_LV:   dat_r <= {24'h000000, opt_mem_r[OBL_SLOT_LV]};
        OBL_IDX_RSV:  dat_r <= {24'h000000, opt_mem_r[OBL_SLOT_RSV]};
        OBL_IDX_DBGM: dat_r <= {24'h000000, opt_mem_r[OBL_SLOT_DBGM]};
        OBL_IDX_DBGS: dat_r <= {24'h000000, opt_mem_r[OBL_SLOT_DBGS]};
        OBL_IDX_OSC:  dat_r <= {30'h0000_0000, osc_stop_r, 1'b0};
        OBL_IDX_STAT: dat_r <= {28'h000_0000, lv_allow_r, cfg_r.cfg_error, swap_r, valid_r};
        default:      dat_r <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // outputs
  assign flash_req_o          = req_r;
  assign flash_addr_o         = addr_r;
  assign cfg_o                = cfg_r;
  assign cfg_valid_o          = valid_r;
  assign wdt_run_o            = wdt_run_r;
  assign illegal_acc_en_o     = wdt_run_r;   // same enable as the counter
  assign wdt_clk_en_o         = wdt_clk_en_r;
  assign slow_osc_stop_o      = osc_stop_r;
  assign lvd_high_thr_o       = lvd_r;
  assign debug_stop_osc_run_o = dbg_keep_r;
  assign lowvolt_wr_allow_o   = lv_allow_r;
  assign wb_dat_o             = dat_r;
  assign wb_ack_o             = ack_r;

  // ==========================================================================
  // assertions
  sequence s_osc_set_try;
    wb_req && wb_we_i && wb_sel_i[0] && wb_idx == OBL_IDX_OSC && wb_dat_i[OBL_OSC_STOP];
  endsequence

  sequence s_locked;
    valid_r && cfg_r.slow_osc_lock && !osc_stop_r;
  endsequence

  a_fetch_primary: assert property (@(posedge clk_i) disable iff (rst_i)
    req_r && !swap_r |-> addr_r >= OBL_PRI_BASE && addr_r <= OBL_PRI_BASE + 16'h0004)
    else $error("fetch left primary block");

  a_fetch_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
    req_r && swap_r |-> addr_r == OBL_MIR_BASE + {13'h0000, idx_r})
    else $error("mirror fetch address wrong");

  a_window_pct: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_r |-> cfg_r.wdt_window_pct ==
      (opt_mem_r[OBL_SLOT_WDT][OBL_WIN_HI:OBL_WIN_LO] == 2'h0 ? OBL_PCT_25 :
       opt_mem_r[OBL_SLOT_WDT][OBL_WIN_HI:OBL_WIN_LO] == 2'h1 ? OBL_PCT_50 :
       opt_mem_r[OBL_SLOT_WDT][OBL_WIN_HI:OBL_WIN_LO] == 2'h2 ? OBL_PCT_75 : OBL_PCT_100))
    else $error("window fraction decode wrong");

  a_wdt_autostart: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_r ##1 valid_r |-> wdt_run_r == opt_mem_r[OBL_SLOT_WDT][OBL_AUTOSTART] &&
                            illegal_acc_en_o == wdt_run_r)
    else $error("watchdog start does not follow autostart");

  a_period_exp: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_r |-> cfg_r.wdt_period_exp ==
                OBL_EXP_MIN + {2'h0, opt_mem_r[OBL_SLOT_WDT][OBL_PER_HI:OBL_PER_LO]})
    else $error("overflow exponent wrong");

  a_osc_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    s_locked and s_osc_set_try |=> !osc_stop_r [*2])
    else $error("locked oscillator was stopped");

  a_wdt_clk_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_r && cfg_r.wdt_autostart && !cfg_r.slow_osc_lock && (halt_i || stop_i) |=> !wdt_clk_en_r)
    else $error("watchdog clock supplied in halt or stop");

  a_selfprog_count: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_r && cfg_r.wdt_autostart && self_prog_i && !halt_i && !stop_i |=> wdt_clk_en_r)
    else $error("watchdog stopped during self-programming");

  a_lvd_level: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_r ##1 valid_r |-> lvd_r == opt_mem_r[OBL_SLOT_LV][OBL_LV_ON])
    else $error("low-voltage level not from option byte");

  a_lv_write_block: assert property (@(posedge clk_i) disable iff (rst_i)
    self_prog_i || boot_swap_i || !prog_mode_i || block_erase_i |=> !lv_allow_r)
    else $error("low-voltage bit change permitted wrongly");

  a_debug_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_r |-> cfg_r.debug_en == opt_mem_r[OBL_SLOT_DBGS][OBL_DEN_HI] &&
                cfg_r.debug_erase_on_fail == (opt_mem_r[OBL_SLOT_DBGS][OBL_DEN_HI:OBL_DEN_LO] == 2'h3))
    else $error("debug enable decode wrong");

  a_cfg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_r |=> valid_r && $stable(cfg_r) && !req_r)
    else $error("settings changed after fetch");

endmodule

// ==== testbench/obl_flash_model.sv ====
// behavioural flash array that answers the loader's option byte reads
`timescale 1ns/1ns
module obl_flash_model (
  input  wire logic        clk_i,   // system clock
  input  wire logic        rst_i,   // synchronous reset
  input  wire logic        req_i,   // read request
  input  wire logic [15:0] addr_i,  // byte address
  input  wire logic [3:0]  lat_i,   // wait cycles before ack
  output logic [7:0]       rdata_o, // read data
  output logic             ack_o    // read done pulse
);
  // ========
  // bank 0 primary, bank 1 mirror; the bench loads both identically
  logic [7:0] mem [0:1][0:4];
  logic [3:0] cnt_r;
  // slow or prompt answer; data off the ack cycle is scrambled so stale bytes never look valid
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i || ack_o) begin
      cnt_r   <= 4'h0;
      ack_o   <= 1'b0;
      rdata_o <= rst_i ? 8'h5A : ~rdata_o;
    end else if (cnt_r >= lat_i) begin
      ack_o   <= 1'b1;
      rdata_o <= mem[addr_i[12]][addr_i[2:0]];
    end else begin
      cnt_r   <= cnt_r + 4'h1;
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// ==== testbench/obl_top_tb.sv ====
// self-checking bench for the option byte loader
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module obl_top_tb;
  import obl_pkg::*;
  logic clk_i, rst_i, boot_swap_i, prog_mode_i, self_prog_i, chip_erase_i, block_erase_i, lv_write_i, halt_i, stop_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, flash_req_o, flash_ack_i, cfg_valid_o, wdt_run_o, illegal_acc_en_o;
  logic wdt_clk_en_o, slow_osc_stop_o, lvd_high_thr_o, debug_stop_osc_run_o, lowvolt_wr_allow_o;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i, lat;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] flash_addr_o;
  logic [7:0]  flash_rdata_i, b0, b1, b3, b4;
  logic [7:0]  bt [5];
  logic [15:0] seen [$];
  obl_cfg_t    cfg_o;
  int          failures, checked;
  logic [6:0]  pct [4] = '{OBL_PCT_25, OBL_PCT_50, OBL_PCT_75, OBL_PCT_100};
  logic [7:0]  b0tab [4] = '{8'h0F, 8'h3F, 8'h40, 8'h70};

  obl_top dut (.clk_i(clk_i), .rst_i(rst_i), .flash_req_o(flash_req_o), .flash_addr_o(flash_addr_o),
    .flash_rdata_i(flash_rdata_i), .flash_ack_i(flash_ack_i), .boot_swap_i(boot_swap_i), .prog_mode_i(prog_mode_i),
    .self_prog_i(self_prog_i), .chip_erase_i(chip_erase_i), .block_erase_i(block_erase_i), .lv_write_i(lv_write_i),
    .halt_i(halt_i), .stop_i(stop_i), .cfg_o(cfg_o), .cfg_valid_o(cfg_valid_o), .wdt_run_o(wdt_run_o),
    .illegal_acc_en_o(illegal_acc_en_o), .wdt_clk_en_o(wdt_clk_en_o), .slow_osc_stop_o(slow_osc_stop_o),
    .lvd_high_thr_o(lvd_high_thr_o), .debug_stop_osc_run_o(debug_stop_osc_run_o),
    .lowvolt_wr_allow_o(lowvolt_wr_allow_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  obl_flash_model flash (.clk_i(clk_i), .rst_i(rst_i), .req_i(flash_req_o), .addr_i(flash_addr_o), .lat_i(lat),
    .rdata_o(flash_rdata_i), .ack_o(flash_ack_i));

  // ========
  // clock and a record of every address whose read was answered
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(negedge clk_i) begin
    if (flash_req_o === 1'b1 && flash_ack_i === 1'b1) seen.push_back(flash_addr_o);
  end

  // ========
  // classic wishbone cycle; ack is sampled at the rising edge, the request stands until then
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // load both banks, reset for five cycles and wait for the fetch to finish
  task automatic fetch(input logic sw, input logic [3:0] l);
    for (int s = 0; s < 2; s++) for (int k = 0; k < 5; k++) flash.mem[s][k] = bt[k];
    @(posedge clk_i);
    rst_i       <= 1'b1;
    boot_swap_i <= sw;
    lat         <= l;
    repeat (5) @(posedge clk_i);
    seen.delete();
    rst_i <= 1'b0;
    do @(negedge clk_i); while (cfg_valid_o !== 1'b1);
    repeat (2) @(negedge clk_i);
    `CHK("fetch count", 5, seen.size())
    for (int k = 0; k < 5; k++) `CHK("fetch addr", (sw ? OBL_MIR_BASE : OBL_PRI_BASE) + 16'(k), seen[k])
    for (int k = 0; k < 5; k++) begin
      wb(1'b0, 12'h200 + 12'(4 * k), 32'h0);
      `CHK("raw byte", {24'h0, bt[k]}, rd)
    end
  endtask

  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ========
  // every window, enable-select and swap case, each fetched at a different flash latency
  initial begin
    rst_i = 1'b1;
    {boot_swap_i, prog_mode_i, self_prog_i, chip_erase_i, block_erase_i, lv_write_i, halt_i, stop_i} = '0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, lat} = '0;
    wb_sel_i = 4'hF;
    for (int i = 0; i < 4; i++) begin
      b0 = b0tab[i];
      b1 = {7'h0, i[0]};
      b3 = {3'h0, i[1], 3'h7, i[0]};
      b4 = {6'h0, i[1:0]};
      bt = '{b0, b1, 8'h00, b3, b4};
      fetch(i[1], 4'(i));
      `CHK("window pct", pct[i], cfg_o.wdt_window_pct)
      `CHK("wdt run", b0[4], wdt_run_o)
      `CHK("illegal det", b0[4], illegal_acc_en_o)
      `CHK("period exp", b0[0] ? 5'h11 : 5'h0A, cfg_o.wdt_period_exp)
      `CHK("lv thr", b1[0], lvd_high_thr_o)
      `CHK("dbg force", b3[0], cfg_o.debug_force)
      `CHK("dbg en", b4[1], cfg_o.debug_en)
      `CHK("dbg erase", b4[1] & b4[0], cfg_o.debug_erase_on_fail)
      `CHK("cfg err", b4 == 8'h01, cfg_o.cfg_error)
      wb(1'b1, 12'h214, 32'h2);
      `CHK("osc stop", ~b0[0], slow_osc_stop_o)
      wb(1'b0, 12'h214, 32'h0);
      `CHK("osc reg", {30'h0, ~b0[0], 1'b0}, rd)
      wb(1'b1, 12'h214, 32'h0);
      halt_i <= 1'b1;
      stop_i <= 1'b1;
      repeat (3) @(negedge clk_i);
      `CHK("wdt clk sleep", b0[4] & b0[0], wdt_clk_en_o)
      `CHK("dbg stop run", b3[0] & ~b3[4], debug_stop_osc_run_o)
      @(posedge clk_i);
      halt_i <= 1'b0;
      stop_i <= 1'b0;
      $display("test config %0d done", i);
    end
    bt = '{8'h30, 8'h00, 8'h00, 8'h1E, 8'h02};
    fetch(1'b0, 4'h0);
    @(posedge clk_i);
    self_prog_i <= 1'b1;
    for (int k = 0; k < 5; k++) flash.mem[0][k] = 8'h00;
    repeat (10) @(negedge clk_i);
    `CHK("wdt clk selfprog", 1'b1, wdt_clk_en_o)
    `CHK("hold autostart", 1'b1, cfg_o.wdt_autostart)
    wb(1'b1, 12'h200, 32'hFF);
    wb(1'b0, 12'h200, 32'h0);
    `CHK("ro byte", 32'h30, rd)
    wb(1'b0, 12'h3FC, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    @(posedge clk_i);
    prog_mode_i  <= 1'b1;
    chip_erase_i <= 1'b1;
    @(posedge clk_i);
    chip_erase_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    `CHK("lv allow selfprog", 1'b0, lowvolt_wr_allow_o)
    @(posedge clk_i);
    self_prog_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    `CHK("lv allow erased", 1'b1, lowvolt_wr_allow_o)
    wb(1'b0, 12'h218, 32'h0);
    `CHK("status", 32'h9, rd)
    @(posedge clk_i);
    block_erase_i <= 1'b1;
    @(posedge clk_i);
    block_erase_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    `CHK("lv allow block", 1'b0, lowvolt_wr_allow_o)
    @(posedge clk_i);
    chip_erase_i <= 1'b1;
    @(posedge clk_i);
    chip_erase_i <= 1'b0;
    lv_write_i   <= 1'b1;
    @(posedge clk_i);
    lv_write_i   <= 1'b0;
    repeat (3) @(negedge clk_i);
    `CHK("lv allow written", 1'b0, lowvolt_wr_allow_o)
    $display("test context done");
    conclude;
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    conclude;
  end
endmodule
